// ---- hdl/cts_defs.svh ----
// constants for the trellis scrambler codec
`ifndef CTS_DEFS_SVH
`define CTS_DEFS_SVH
`define CTS_SCR_LEN 23
`define CTS_TAP_CUST 18
`define CTS_TAP_EXCH 5
`define CTS_INFO_64 3'd5
`define CTS_INFO_128 3'd6
`define CTS_INFO_UNC 3'd6
`define CTS_LOCK_ONES 5'd23
`define CTS_CLK_HZ 25'd10000000
`define CTS_BAUD_64 25'd233600
`define CTS_BAUD_128 25'd386667
`define CTS_PPM_64 110
`define CTS_PPM_128 90
`define CTS_FIFO_DEPTH 16
`define CTS_SYM_W 7
`endif

// ---- hdl/cts_pkg.sv ----
// types for the trellis scrambler codec
package cts_pkg;
    typedef logic [6:0] cts_sym_t;
    typedef enum logic [1:0] {
        CTS_SELF = 2'b01,
        CTS_LOCK = 2'b10
    } cts_scr_e;
endpackage

// ---- hdl/cts_codec.sv ----
// trellis coder, scramblers and symbol fifo for the cap transceiver
`timescale 1ns/10ps
`default_nettype none
`include "cts_defs.svh"

// ==========================================
// symbol fifo
module cts_fifo #(
    parameter int W = 7,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    wire logic empty = (wp_r == rp_r);
    wire logic full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire logic wr = in_valid && !full;
    wire logic rd = out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (wr) begin
                wp_r <= wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (wr) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==========================================
// codec top
// Operation
// - coded 64-point at 1168 kbit/s, coded 128-point at 2320 kbit/s.
// - two-dimensional eight-state trellis code, no differential coding.
// - six bits per symbol at 64 points, seven at 128; one redundant.
// - 64-point mode groups five scrambled bits per symbol, first bit lsb.
// - 128-point mode groups six scrambled bits per symbol, first bit lsb.
// - first two group bits feed systematic encoder giving one redundant bit.
// - redundant bit plus info bits select the constellation point.
// - start-up sends uncoded 64-point symbols, encoder bypassed.
// - coded signal is Tomlinson precoded downstream of the code word.
// - customer unit scrambles with taps 18,23, descrambles with opposite taps.
// - exchange unit scrambles with taps 5,23.
// - self-synchronizing scrambler outputs input divided by polynomial.
// - self-synchronizing descrambler multiplies input by polynomial.
// - data mode: free-running sequence xored in and xored out.
// - switch to locked only during all-ones data, ends switch independently.
// - every frame bit passes the scrambler, overhead and stuffing included.
// - 1168 kbit/s symbols at 233.60 kbaud within 110 ppm.
// - 2320 kbit/s symbols at 386.667 kbaud within 90 ppm.
module cts_codec (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // configuration
    input wire logic exchange_side_unit,
    input wire logic pair128,
    input wire logic tx_lock_req,
    input wire logic rx_lock_req,
    // transmit bits from framer
    input wire logic tx_bit,
    input wire logic tx_bit_valid,
    output logic tx_bit_ready,
    // transmit symbols to modulator
    output logic [`CTS_SYM_W-1:0] tx_sym_code,
    output logic tx_sym_valid,
    // receive symbols from demodulator
    input wire logic [`CTS_SYM_W-1:0] rx_sym_code,
    input wire logic rx_sym_valid,
    output logic rx_sym_ready,
    // receive bits to framer
    output logic rx_bit,
    output logic rx_bit_valid,
    // status
    output logic tx_locked,
    output logic rx_locked
);
    // tap position, taken from the shift register of the given direction
    function automatic logic scr_fb(input logic [22:0] r, input logic exch);
        scr_fb = (exch ? r[`CTS_TAP_EXCH-1] : r[`CTS_TAP_CUST-1]) ^ r[`CTS_SCR_LEN-1];
    endfunction

    // 8-state systematic code: next state from state and two info bits
    function automatic logic [2:0] trl_next(input logic [2:0] w, input logic i1,
                                            input logic i2);
        trl_next = {w[1] ^ i2, w[0] ^ i1 ^ w[2], w[2] ^ i2 ^ i1};
    endfunction

    // group size for a given lock state
    function automatic logic [2:0] grp_size(input logic locked, input logic p128);
        grp_size = !locked ? `CTS_INFO_UNC : (p128 ? `CTS_INFO_128 : `CTS_INFO_64);
    endfunction

    // ==========================================
    // transmit scrambler and grouping
    cts_pkg::cts_scr_e tx_st_r;
    cts_pkg::cts_scr_e tx_st_nxt;
    logic [22:0] scr_r;
    logic [4:0] tx_ones_r;
    logic [5:0] grp_r;
    logic [2:0] cnt_r;
    logic [2:0] trellis_state_bits_r;
    wire logic tx_lk = (tx_st_r == cts_pkg::CTS_LOCK);
    wire logic [2:0] tx_size = grp_size(tx_lk, pair128);
    wire logic grp_full = (cnt_r == tx_size);
    wire logic tx_take = tx_bit_valid && !grp_full;
    wire logic scr_seq = scr_fb(scr_r, exchange_side_unit);
    wire logic scr_out = tx_bit ^ scr_seq;
    wire logic scr_in = tx_lk ? scr_seq : scr_out;
    logic fifo_in_ready;
    wire logic push = grp_full && fifo_in_ready;
    wire logic tx_ones_full = (tx_ones_r == `CTS_LOCK_ONES);
    wire logic tx_bound = (cnt_r == 3'd0);
    wire logic group_first_info_bit = grp_r[0];
    wire logic group_second_info_bit = grp_r[1];
    wire logic trellis_redundant_bit = trellis_state_bits_r[0];
    wire logic [2:0] trl_nxt = trl_next(trellis_state_bits_r, group_first_info_bit,
                                        group_second_info_bit);
    wire cts_pkg::cts_sym_t sym_coded = pair128 ?
        {grp_r[5:0], trellis_redundant_bit} :
        {1'b0, grp_r[4:0], trellis_redundant_bit};
    wire cts_pkg::cts_sym_t sym_unc = {1'b0, grp_r[5:0]};
    wire cts_pkg::cts_sym_t sym_word = tx_lk ? sym_coded : sym_unc;
    assign tx_bit_ready = !grp_full;
    assign tx_locked = tx_lk;

    always_comb begin
        tx_st_nxt = tx_st_r;
        case (tx_st_r)
            cts_pkg::CTS_SELF: begin
                if (tx_lock_req && tx_ones_full && tx_bound) begin
                    tx_st_nxt = cts_pkg::CTS_LOCK;
                end
            end
            cts_pkg::CTS_LOCK: begin
                if (!tx_lock_req && tx_bound) begin
                    tx_st_nxt = cts_pkg::CTS_SELF;
                end
            end
            default: begin
                tx_st_nxt = cts_pkg::CTS_SELF;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_r <= cts_pkg::CTS_SELF;
            scr_r <= '0;
            tx_ones_r <= '0;
        end else begin
            tx_st_r <= tx_st_nxt;
            if (tx_take) begin
                scr_r <= {scr_r[21:0], scr_in};
                tx_ones_r <= !tx_bit ? 5'd0 : (tx_ones_full ? tx_ones_r : tx_ones_r + 5'd1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            grp_r <= '0;
            cnt_r <= '0;
            trellis_state_bits_r <= '0;
        end else begin
            if (push) begin
                cnt_r <= '0;
                trellis_state_bits_r <= tx_lk ? trl_nxt : 3'h0;
            end else if (tx_take) begin
                grp_r[cnt_r] <= scr_out;
                cnt_r <= cnt_r + 3'd1;
            end
        end
    end

    // ==========================================
    // symbol fifo and symbol-rate tick
    logic fifo_out_valid;
    cts_pkg::cts_sym_t fifo_out_data;
    logic [24:0] acc_r;
    logic sym_valid_r;
    cts_pkg::cts_sym_t sym_code_r;
    // accumulator ratio is exact at 233.6 kbaud and under 1 ppm off at 386.667
    wire logic [24:0] baud = pair128 ? `CTS_BAUD_128 : `CTS_BAUD_64;
    wire logic [24:0] acc_sum = acc_r + baud;
    wire logic tick = (acc_sum >= `CTS_CLK_HZ);
    assign tx_sym_code = sym_code_r;
    assign tx_sym_valid = sym_valid_r;

    cts_fifo #(.W(`CTS_SYM_W), .D(`CTS_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .in_valid(grp_full),
        .in_ready(fifo_in_ready),
        .in_data(sym_word),
        .out_valid(fifo_out_valid),
        .out_ready(tick),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= '0;
            sym_valid_r <= 1'b0;
            sym_code_r <= '0;
        end else begin
            acc_r <= tick ? acc_sum - `CTS_CLK_HZ : acc_sum;
            sym_valid_r <= tick && fifo_out_valid;
            if (tick && fifo_out_valid) begin
                sym_code_r <= fifo_out_data;
            end
        end
    end

    // ==========================================
    // receive serialiser and descrambler
    cts_pkg::cts_scr_e rx_st_r;
    cts_pkg::cts_scr_e rx_st_nxt;
    logic [22:0] dsc_r;
    logic [4:0] rx_ones_r;
    logic [5:0] rxs_r;
    logic [2:0] left_r;
    logic rx_bit_r;
    logic rx_bit_valid_r;
    wire logic rx_lk = (rx_st_r == cts_pkg::CTS_LOCK);
    wire logic rx_take = rx_sym_valid && (left_r == 3'd0);
    wire logic rx_shift = (left_r != 3'd0);
    wire logic dsc_seq = scr_fb(dsc_r, !exchange_side_unit);
    wire logic dsc_out = rxs_r[0] ^ dsc_seq;
    wire logic dsc_in = rx_lk ? dsc_seq : rxs_r[0];
    wire logic rx_ones_full = (rx_ones_r == `CTS_LOCK_ONES);
    wire logic [5:0] rx_info = rx_lk ? rx_sym_code[6:1] : rx_sym_code[5:0];
    assign rx_sym_ready = (left_r == 3'd0);
    assign rx_bit = rx_bit_r;
    assign rx_bit_valid = rx_bit_valid_r;
    assign rx_locked = rx_lk;

    always_comb begin
        rx_st_nxt = rx_st_r;
        case (rx_st_r)
            cts_pkg::CTS_SELF: begin
                if (rx_lock_req && rx_ones_full && !rx_shift) begin
                    rx_st_nxt = cts_pkg::CTS_LOCK;
                end
            end
            cts_pkg::CTS_LOCK: begin
                if (!rx_lock_req && !rx_shift) begin
                    rx_st_nxt = cts_pkg::CTS_SELF;
                end
            end
            default: begin
                rx_st_nxt = cts_pkg::CTS_SELF;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_r <= cts_pkg::CTS_SELF;
            dsc_r <= '0;
            rx_ones_r <= '0;
            rxs_r <= '0;
            left_r <= '0;
            rx_bit_r <= 1'b0;
            rx_bit_valid_r <= 1'b0;
        end else begin
            rx_st_r <= rx_st_nxt;
            rx_bit_valid_r <= rx_shift;
            if (rx_take) begin
                rxs_r <= rx_info;
                left_r <= grp_size(rx_lk, pair128);
            end else if (rx_shift) begin
                rxs_r <= {1'b0, rxs_r[5:1]};
                left_r <= left_r - 3'd1;
                dsc_r <= {dsc_r[21:0], dsc_in};
                rx_bit_r <= dsc_out;
                rx_ones_r <= !dsc_out ? 5'd0 : (rx_ones_full ? rx_ones_r : rx_ones_r + 5'd1);
            end
        end
    end

    // ==========================================
    // checks
    a_group_size: assert property (@(posedge clock) disable iff (!rst_b)
        push |-> cnt_r == (tx_lk ? (pair128 ? 3'd6 : 3'd5) : 3'd6))
        else $error("symbol pushed with wrong group size");
    a_lock_ones: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(tx_lk) |-> $past(tx_ones_r) == 5'd23)
        else $error("transmit locked without all-ones run");
    a_uncoded_start: assert property (@(posedge clock) disable iff (!rst_b)
        push && !tx_lk |-> sym_word == {1'b0, grp_r})
        else $error("start-up symbol not uncoded");
    a_code_redundant: assert property (@(posedge clock) disable iff (!rst_b)
        push && tx_lk |=> trellis_state_bits_r == trl_next($past(trellis_state_bits_r),
                                     $past(grp_r[0]), $past(grp_r[1])))
        else $error("trellis state not advanced by first two bits");
    a_self_sync: assert property (@(posedge clock) disable iff (!rst_b)
        tx_take && !tx_lk |=> scr_r[0] == $past(scr_out))
        else $error("self-sync scrambler did not feed back output");
    a_rx_locked_seq: assert property (@(posedge clock) disable iff (!rst_b)
        rx_shift && rx_lk |=> dsc_r[0] == $past(dsc_seq))
        else $error("locked descrambler did not free-run");
    a_rx_burst: assert property (@(posedge clock) disable iff (!rst_b)
        rx_take |=> ##1 rx_bit_valid_r [*5])
        else $error("received symbol did not yield its bits");
    a_tick_spacing: assert property (@(posedge clock) disable iff (!rst_b)
        tick |=> !tick ##1 !tick)
        else $error("symbol tick faster than symbol rate");
    a_sym_from_tick: assert property (@(posedge clock) disable iff (!rst_b)
        sym_valid_r |-> $past(tick))
        else $error("symbol issued off the symbol tick");
endmodule
`default_nettype wire

// ---- tb/cts_far_end.sv ----
// far-end model: demodulator feeding the codec and sink of its symbols
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// far end
module cts_far_end (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // symbols from the codec
    input wire cts_pkg::cts_sym_t tx_sym_code,
    input wire logic tx_sym_valid,
    // symbols to the codec
    output var cts_pkg::cts_sym_t rx_sym_code,
    output logic rx_sym_valid,
    input wire logic rx_sym_ready,
    // idle cycles between sent symbols
    input wire logic [3:0] gap
);
    cts_pkg::cts_sym_t send_q[$];
    cts_pkg::cts_sym_t got_q[$];
    int got_t[$];
    int cyc = 0;
    int wait_n = 0;
    logic taken = 1'b0;

    always @(posedge clock) begin
        cyc <= cyc + 1;
        taken <= rx_sym_valid & rx_sym_ready;
        if (tx_sym_valid) begin
            got_q.push_back(tx_sym_code);
            got_t.push_back(cyc);
        end
    end

    // codec lock state is never looked at: each end switches alone
    initial begin
        rx_sym_valid = 1'b0;
        rx_sym_code = 7'h2A;
        forever begin
            @(negedge clock);
            if (rx_sym_valid && taken) begin
                rx_sym_valid = 1'b0;
                rx_sym_code = ~rx_sym_code;
                wait_n = int'(gap);
            end else if (!rx_sym_valid && wait_n > 0) begin
                wait_n = wait_n - 1;
            end else if (!rx_sym_valid && rst_b && send_q.size() > 0) begin
                rx_sym_code = send_q.pop_front();
                rx_sym_valid = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/cts_codec_tb_top.sv ----
// self-checking bench for the trellis scrambler codec
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// bench top
module cts_codec_tb_top;
    typedef struct packed {
        logic [5:0] tx_in;
        cts_pkg::cts_sym_t tx_exp;
        cts_pkg::cts_sym_t rx_code;
        logic [5:0] rx_exp;
    } cts_row_s;
    localparam int NROW = 24;
    logic clock;
    logic rst_b = 1'b0;
    logic exchange_side_unit = 1'b0;
    logic pair128 = 1'b0;
    logic tx_lock_req = 1'b0;
    logic rx_lock_req = 1'b0;
    logic tx_bit = 1'b0;
    logic tx_bit_valid = 1'b0;
    logic tx_take = 1'b0;
    logic tx_bit_ready, tx_sym_valid, rx_sym_valid, rx_sym_ready, rx_bit, rx_bit_valid;
    logic tx_locked, rx_locked;
    logic [3:0] gap = 4'h0;
    cts_pkg::cts_sym_t tx_sym_code, rx_sym_code;
    cts_row_s rows[NROW];
    logic [22:0] tx_s, rx_s;
    logic rx_got[$];
    int tx_tap, rx_tap, max_low;
    int low_run = 0;
    int n_mismatch = 0;
    int comparisons = 0;

    cts_codec uut (.clock(clock), .rst_b(rst_b), .exchange_side_unit(exchange_side_unit),
        .pair128(pair128), .tx_lock_req(tx_lock_req), .rx_lock_req(rx_lock_req),
        .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready),
        .tx_sym_code(tx_sym_code), .tx_sym_valid(tx_sym_valid), .rx_sym_code(rx_sym_code),
        .rx_sym_valid(rx_sym_valid), .rx_sym_ready(rx_sym_ready), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .tx_locked(tx_locked), .rx_locked(rx_locked));
    cts_far_end far (.clock(clock), .rst_b(rst_b), .tx_sym_code(tx_sym_code),
        .tx_sym_valid(tx_sym_valid), .rx_sym_code(rx_sym_code), .rx_sym_valid(rx_sym_valid),
        .rx_sym_ready(rx_sym_ready), .gap(gap));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        tx_take <= tx_bit_valid & tx_bit_ready;
        if (rx_bit_valid) rx_got.push_back(rx_bit);
        low_run = (rst_b && !tx_bit_ready) ? low_run + 1 : 0;
        if (low_run > max_low) max_low = low_run;
    end

    // ==========================================
    // compares and reference models
    task automatic cmp_sym(input cts_pkg::cts_sym_t got, input cts_pkg::cts_sym_t exp,
                           input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic tx_scr(input logic b, output logic o);
        o = b ^ tx_s[tx_tap - 1] ^ tx_s[22];
        tx_s = {tx_s[21:0], o};
    endtask

    task automatic rx_dscr(input logic b, output logic o);
        o = b ^ rx_s[rx_tap - 1] ^ rx_s[22];
        rx_s = {rx_s[21:0], b};
    endtask

    task automatic build_rows;
        logic o;
        tx_s = 23'h000000;
        rx_s = 23'h000000;
        for (int i = 0; i < NROW; i++) begin
            rows[i].tx_in = 6'(i * 11 + 5);
            rows[i].rx_code = 7'(i * 37 + 3);
            rows[i].tx_exp = 7'h00;
            for (int k = 0; k < 6; k++) begin
                tx_scr(rows[i].tx_in[k], o);
                rows[i].tx_exp[k] = o;
                rx_dscr(rows[i].rx_code[k], o);
                rows[i].rx_exp[k] = o;
            end
        end
    endtask

    task automatic send_bit(input logic b);
        tx_bit = b;
        for (int t = 0; t < 300; t++) begin
            @(negedge clock);
            if (tx_take === 1'b1) break;
        end
    endtask

    // ==========================================
    // tests
    task automatic run_phase(input logic exch, input logic p128, input logic [3:0] slow);
        int lo;
        int d;
        rst_b = 1'b0;
        exchange_side_unit = exch;
        pair128 = p128;
        tx_lock_req = 1'b0;
        rx_lock_req = 1'b0;
        gap = slow;
        tx_tap = exch ? 5 : 18;
        rx_tap = exch ? 18 : 5;
        far.got_q.delete();
        far.got_t.delete();
        rx_got.delete();
        build_rows();
        repeat (10) @(negedge clock);
        cmp_bit(tx_bit_ready, 1'b1, "tx ready in reset");
        cmp_bit(rx_sym_ready, 1'b1, "rx ready in reset");
        cmp_bit(tx_sym_valid | rx_bit_valid | tx_locked | rx_locked, 1'b0, "outputs in reset");
        rst_b = 1'b1;
        max_low = 0;
        for (int i = 0; i < NROW; i++) far.send_q.push_back(rows[i].rx_code);
        tx_bit_valid = 1'b1;
        for (int i = 0; i < NROW * 6; i++) send_bit(rows[i / 6].tx_in[i % 6]);
        tx_bit_valid = 1'b0;
        for (int t = 0; t < 2000 && far.got_q.size() < NROW; t++) @(negedge clock);
        // quiet span: an empty fifo must not emit filler symbols
        repeat (200) @(negedge clock);
        lo = p128 ? 25 : 42;
        for (int i = 0; i < NROW; i++) begin
            cmp_sym(far.got_q[i], rows[i].tx_exp, "tx symbol");
            for (int k = 0; k < 6; k++) begin
                cmp_bit(rx_got[i * 6 + k], rows[i].rx_exp[k], "rx bit");
            end
            if (i > 2) begin
                d = far.got_t[i] - far.got_t[i - 1];
                cmp_bit(d == lo || d == lo + 1, 1'b1, "symbol spacing");
            end
        end
        cmp_bit(max_low > 1, 1'b1, "fifo refused when full");
        cmp_bit(far.got_q.size() == NROW, 1'b1, "no filler symbols");
        $display("test phase exch=%0d p128=%0d done", exch, p128);
    endtask

    task automatic lock_test(input logic p128);
        cts_pkg::cts_sym_t code;
        cts_pkg::cts_sym_t exp_q[$];
        logic rx_exp_q[$];
        logic [5:0] g;
        logic [2:0] w;
        logic d;
        logic sq;
        logic o;
        int gs;
        int n;
        rst_b = 1'b0;
        pair128 = p128;
        tx_lock_req = 1'b1;
        rx_lock_req = 1'b1;
        tx_s = 23'h000000;
        rx_s = 23'h000000;
        far.got_q.delete();
        far.got_t.delete();
        rx_got.delete();
        repeat (10) @(negedge clock);
        rst_b = 1'b1;
        gs = p128 ? 6 : 5;
        w = 3'h0;
        n = 0;
        // transmit: 25 ones lock the scrambler at the fifth group, coded data follows
        tx_bit_valid = 1'b1;
        for (int j = 0; j < 12; j++) begin
            g = 6'h00;
            for (int k = 0; k < (j < 4 ? 6 : gs); k++) begin
                d = (n < 25) ? 1'b1 : rows[j].tx_in[k];
                sq = tx_s[tx_tap - 1] ^ tx_s[22];
                o = d ^ sq;
                tx_s = {tx_s[21:0], (n > 24) ? sq : o};
                g[k] = o;
                n++;
                send_bit(d);
            end
            if (j < 4) exp_q.push_back({1'b0, g});
            else if (p128) exp_q.push_back({g, w[0]});
            else exp_q.push_back({1'b0, g[4:0], w[0]});
            if (j >= 4) w = {w[1] ^ g[1], w[0] ^ g[0] ^ w[2], w[2] ^ g[1] ^ g[0]};
        end
        tx_bit_valid = 1'b0;
        for (int t = 0; t < 2000 && far.got_q.size() < 12; t++) @(negedge clock);
        cmp_bit(tx_locked, 1'b1, "tx locked after ones");
        for (int j = 0; j < 12; j++) begin
            cmp_sym(far.got_q[j], exp_q[j], "locked tx symbol");
        end
        // receive: four start-up symbols of ones, then coded symbols once locked
        for (int i = 0; i < 4; i++) begin
            code = 7'h00;
            for (int k = 0; k < 6; k++) begin
                code[k] = ~(rx_s[rx_tap - 1] ^ rx_s[22]);
                rx_dscr(code[k], o);
            end
            far.send_q.push_back(code);
        end
        for (int t = 0; t < 500 && rx_got.size() < 24; t++) @(negedge clock);
        repeat (4) @(negedge clock);
        for (int k = 0; k < 24; k++) cmp_bit(rx_got[k], 1'b1, "rx ones");
        cmp_bit(rx_locked, 1'b1, "rx locked after ones");
        for (int i = 0; i < 8; i++) begin
            code = rows[i].rx_code;
            for (int k = 0; k < gs; k++) begin
                sq = rx_s[rx_tap - 1] ^ rx_s[22];
                rx_exp_q.push_back(code[k + 1] ^ sq);
                rx_s = {rx_s[21:0], sq};
            end
            far.send_q.push_back(code);
        end
        for (int t = 0; t < 500 && rx_got.size() < 24 + 8 * gs; t++) @(negedge clock);
        foreach (rx_exp_q[m]) begin
            cmp_bit(rx_got[24 + m], rx_exp_q[m], "locked rx bit");
        end
        $display("test lock p128=%0d done", p128);
    endtask

    task automatic finish_test;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        run_phase(1'b0, 1'b0, 4'h0);
        lock_test(1'b0);
        run_phase(1'b1, 1'b1, 4'h5);
        lock_test(1'b1);
        finish_test();
    end

    // about six times the expected run length
    initial begin
        #2000000;
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
